// File: src/ous_pkg.sv
// Shared constants and types for the serial-line interrupt scanner
package ous_pkg;
  // Number of serial lines and scanner width
  localparam int NUM_LINES = 8;
  localparam int POS_W = 4;
  // Summary register selects on the low three address bits
  localparam logic [2:0] ADDR_INT_SUMMARY = 3'h6;
  localparam logic [2:0] ADDR_MODEM_CHANGE = 3'h7;
  // Interrupt summary field positions
  localparam int ISR_REQ_BIT = 7;
  localparam int ISR_LINE_LSB = 1;
  localparam int ISR_DIR_BIT = 0;
  // Reset values
  localparam logic [3:0] POS_RESET = 4'h0;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  // Depth of the pin synchroniser and the cycles to fill it
  localparam int SYNC_DEPTH = 3;
  localparam logic [1:0] PRIME_CYCLES = 2'h3;
  // Bus control pins idle high
  localparam logic [2:0] CTL_IDLE = 3'h7;
  // Scanner states
  typedef enum logic [1:0] {
    SCAN = 2'b01,
    STOP = 2'b10
  } ous_scan_state_type;
  // Character length in half bit times: start, data, parity, stop
  function automatic logic [4:0] char_half_bits(input logic [1:0] data_sel,
                                                input logic parity,
                                                input logic [1:0] stop_sel);
    logic [4:0] bits;
    logic [4:0] stop_half;
    bits = 5'h6 + {3'h0, data_sel} + {4'h0, parity};
    stop_half = (stop_sel == 2'h0) ? 5'h2 : ((stop_sel == 2'h1) ? 5'h3 : 5'h4);
    char_half_bits = {bits[3:0], 1'b0} + stop_half;
  endfunction : char_half_bits
endpackage : ous_pkg

// File: src/ous_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module ous_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Asynchronous pins
  input wire logic [W-1:0] i_pin,
  // Filtered level and one-cycle change pulse per bit
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_change
);
  import ous_pkg::*;

  logic [W-1:0] s1; // First stage, read only by s2
  logic [W-1:0] s2; // Second stage
  logic [W-1:0] s3; // Third stage
  logic [1:0] prime_cnt; // Cycles since reset release
  logic primed; // Chain holds real pin samples
  logic [W-1:0] agree; // Second and third stage match

  assign primed = (prime_cnt == PRIME_CYCLES);
  assign agree = ~(s2 ^ s3);

  // Shift chain
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end
    else
    begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Priming count; changes before the chain fills are not reported
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      prime_cnt <= 2'h0;
    else if (!primed)
      prime_cnt <= prime_cnt + 2'h1;
  end

  // Accepted level; a pulse shorter than two clocks may be missed
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_level <= INIT;
      o_change <= '0;
    end
    else if (!primed)
    begin
      // Follow stage two so the level held at release is never a change
      o_level <= s2;
      o_change <= '0;
    end
    else
    begin
      o_level <= (o_level & ~agree) | (s3 & agree);
      o_change <= agree & (s3 ^ o_level);
    end
  end

  property p_no_change_unprimed;
    @(posedge i_clk) disable iff (!i_reset_n)
    !primed |=> (o_change == '0);
  endproperty
  a_no_change_unprimed: assert property (p_no_change_unprimed)
    else $error("change reported before synchroniser primed");
endmodule : ous_pin_sync

// File: src/ous_int_scanner.sv
// Interrupt scanner and modem change summary for eight serial lines
`timescale 1ns/1ps
module ous_int_scanner (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Processor bus pins
  input wire logic i_cs_n,
  input wire logic i_ds_n,
  input wire logic i_wr_n,
  input wire logic [5:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Modem status pins, one per line
  input wire logic [ous_pkg::NUM_LINES-1:0] i_dsr,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_dcd,
  // Per-line flags and enables from the line logic
  input wire logic [ous_pkg::NUM_LINES-1:0] i_rx_data_ready,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_rx_int_enable,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_modem_int_enable,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_tx_holding_empty,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_tx_int_enable,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_ser_idle,
  // Per-line service pulses from the line logic
  input wire logic [ous_pkg::NUM_LINES-1:0] i_rx_buf_read,
  input wire logic [ous_pkg::NUM_LINES-1:0] i_tx_hold_write,
  // Character format of the line being timed
  input wire logic [1:0] i_fmt_data_bits,
  input wire logic i_fmt_parity,
  input wire logic [1:0] i_fmt_stop,
  // Interrupt outputs
  output logic o_irq_n,
  output logic [2:0] o_int_line_number,
  output logic o_int_direction,
  // Status outputs
  output logic [ous_pkg::NUM_LINES-1:0] o_modem_change_flag,
  output logic [ous_pkg::NUM_LINES-1:0] o_tx_fully_empty,
  output logic [4:0] o_char_half_bits
);
  import ous_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  // Synchronised bus pins
  logic [2:0] ctl_level; // {wr_n, ds_n, cs_n}
  logic [13:0] ad_level; // {addr, data}
  logic [5:0] bus_addr; // Accepted address
  logic [7:0] bus_data; // Accepted write data
  logic bus_wr_n; // Accepted write select
  logic acc_now; // Chip select and strobe both active
  logic acc_prev; // Access state one clock ago
  logic acc_start; // First cycle of an access
  logic sel_isr; // Access targets interrupt summary
  logic sel_mcs; // Access targets modem change summary

  // Modem change detection
  logic [NUM_LINES-1:0] dsr_change; // Accepted change on status A
  logic [NUM_LINES-1:0] dcd_change; // Accepted change on status B
  logic [NUM_LINES-1:0] mc_set; // Change event per line
  logic [NUM_LINES-1:0] mc_clr; // One-written bits of a write

  // Scanner
  ous_scan_state_type state; // Scanning or stopped
  ous_scan_state_type next_state; // Next scanner state
  logic [POS_W-1:0] pos; // Scan position
  logic [POS_W-1:0] next_pos; // Next scan position
  logic [2:0] line; // Line under test
  logic rx_dr_cond; // Data ready request at line
  logic rx_mc_cond; // Modem change request at line
  logic tx_cond; // Transmit request at line
  logic hit; // Condition present at position
  logic stop_dr; // Stop was for data ready
  logic release_req; // Current request has been serviced
  logic [7:0] isr_value; // Interrupt summary image

  // Bus control pins come from the processor clock domain
  ous_pin_sync #(
    .W(3),
    .INIT(CTL_IDLE)
  ) u_ctl_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin({i_wr_n, i_ds_n, i_cs_n}),
    .o_level(ctl_level),
    .o_change()
  );

  // Address and data travel through the same depth as the strobes
  ous_pin_sync #(
    .W(14),
    .INIT(14'h0000)
  ) u_ad_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin({i_addr, i_data}),
    .o_level(ad_level),
    .o_change()
  );

  // Modem status pins of all lines
  ous_pin_sync #(
    .W(NUM_LINES),
    .INIT(FLAG_RESET)
  ) u_dsr_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_dsr),
    .o_level(),
    .o_change(dsr_change)
  );

  ous_pin_sync #(
    .W(NUM_LINES),
    .INIT(FLAG_RESET)
  ) u_dcd_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_dcd),
    .o_level(),
    .o_change(dcd_change)
  );

  assign bus_addr = ad_level[13:8];
  assign bus_data = ad_level[7:0];
  assign bus_wr_n = ctl_level[2];
  assign acc_now = ~ctl_level[0] & ~ctl_level[1];
  assign acc_start = acc_now & ~acc_prev;
  // Line select bits 5:3 play no part in the decode
  assign sel_isr = (bus_addr[2:0] == ADDR_INT_SUMMARY);
  assign sel_mcs = (bus_addr[2:0] == ADDR_MODEM_CHANGE);
  // Access edge tracking
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      acc_prev <= 1'b0;
    else
      acc_prev <= acc_now;
  end

  // Either status input toggling marks the line
  assign mc_set = dsr_change | dcd_change;
  // Write-one-to-clear, taken once per access
  assign mc_clr = (acc_start && !bus_wr_n && sel_mcs) ? bus_data : '0;

  // Summary flags; a change landing with its clear is kept
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_modem_change_flag <= FLAG_RESET;
    else
      o_modem_change_flag <= (o_modem_change_flag & ~mc_clr) | mc_set;
  end

  // Conditions at the position under test
  assign line = pos[2:0];
  assign rx_dr_cond = i_rx_data_ready[line] & i_rx_int_enable[line];
  assign rx_mc_cond = o_modem_change_flag[line] & i_rx_int_enable[line]
                      & i_modem_int_enable[line];
  assign tx_cond = i_tx_holding_empty[line] & i_tx_int_enable[line];
  // Upper half of the count tests transmitters
  assign hit = pos[3] ? tx_cond : (rx_dr_cond | rx_mc_cond);

  // Service events that end the standing request
  always_comb
  begin
    if (pos[3])
      release_req = i_tx_hold_write[line] | ~i_tx_int_enable[line];
    else if (stop_dr)
      release_req = i_rx_buf_read[line] | ~i_rx_int_enable[line];
    else
      release_req = ~i_modem_int_enable[line] | ~i_rx_int_enable[line]
                    | ~o_modem_change_flag[line];
  end

  // Scanner next state and position
  always_comb
  begin
    next_state = state;
    next_pos = pos;
    unique case (state)
      SCAN:
      begin
        if (hit)
          next_state = STOP;
        else
          next_pos = pos + 4'h1;
      end
      STOP:
      begin
        if (release_req)
        begin
          next_state = SCAN;
          // Receivers share fairly; transmitters yield to receivers
          if (pos[3])
            next_pos = POS_RESET;
          else
            next_pos = pos + 4'h1;
        end
      end
      default:
      begin
        next_state = SCAN;
        next_pos = POS_RESET;
      end
    endcase
  end

  // Scanner registers
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state <= SCAN;
      pos <= POS_RESET;
    end
    else
    begin
      state <= next_state;
      pos <= next_pos;
    end
  end

  // Remember which receive cause stopped the scan; data ready wins
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      stop_dr <= 1'b0;
    else if (state == SCAN && hit)
      stop_dr <= rx_dr_cond;
  end

  // Line number and direction follow the counter; valid only while requesting
  assign o_int_line_number = pos[2:0];
  assign o_int_direction = pos[3];
  // A level output: with modem interrupts the host must not use edges
  assign o_irq_n = (state != STOP);

  // Interrupt summary image
  always_comb
  begin
    isr_value = 8'h00;
    isr_value[ISR_REQ_BIT] = (state == STOP);
    isr_value[ISR_LINE_LSB +: 3] = pos[2:0];
    isr_value[ISR_DIR_BIT] = pos[3];
  end

  // Read data captured at the start of a read access
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_data <= DATA_RESET;
    else if (acc_start && bus_wr_n)
    begin
      if (sel_isr)
        o_data <= isr_value;
      else if (sel_mcs)
        o_data <= o_modem_change_flag;
      else
        o_data <= DATA_RESET;
    end
  end

  // Drive the data pins only for our own registers during a read
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_data_oe <= 1'b0;
    else
      o_data_oe <= acc_now & bus_wr_n & (sel_isr | sel_mcs);
  end

  // Fully empty once holding register and serializer are both done
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_tx_fully_empty <= FLAG_RESET;
    else
      o_tx_fully_empty <= i_tx_holding_empty & i_ser_idle;
  end

  // Character time in half bits, covers one and a half stop bits
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_char_half_bits <= 5'h00;
    else
      o_char_half_bits <= char_half_bits(i_fmt_data_bits, i_fmt_parity,
                                         i_fmt_stop);
  end

  property p_scan_advance;
    (state == SCAN) && !hit |=> (pos == $past(pos) + 4'h1) && (state == SCAN);
  endproperty
  a_scan_advance: assert property (p_scan_advance)
    else $error("scanner did not advance by one");
  property p_stop_on_hit;
    (state == SCAN) && hit |=> !o_irq_n && $stable(pos);
  endproperty
  a_stop_on_hit: assert property (p_stop_on_hit)
    else $error("scanner did not stop on a condition");
  property p_hold_stop;
    (state == STOP) && !release_req |=> (state == STOP) && $stable(pos);
  endproperty
  a_hold_stop: assert property (p_hold_stop)
    else $error("request dropped before service");
  property p_tx_restart;
    (state == STOP) && release_req && pos[3] |=> (pos == 4'h0) && o_irq_n;
  endproperty
  a_tx_restart: assert property (p_tx_restart)
    else $error("scan did not restart at zero after transmit");
  property p_rx_resume;
    (state == STOP) && release_req && !pos[3] |=> pos == $past(pos) + 4'h1;
  endproperty
  a_rx_resume: assert property (p_rx_resume)
    else $error("scan did not resume after receive");
  property p_rx_cond;
    (state == SCAN) && !pos[3] && i_rx_data_ready[line] && i_rx_int_enable[line]
    |=> !o_irq_n ##0 !o_int_direction;
  endproperty
  a_rx_cond: assert property (p_rx_cond)
    else $error("receive condition not reported");
  property p_tx_cond;
    (state == SCAN) && pos[3] && i_tx_holding_empty[line] && i_tx_int_enable[line]
    |=> !o_irq_n ##0 o_int_direction;
  endproperty
  a_tx_cond: assert property (p_tx_cond)
    else $error("transmit condition not reported");
  property p_flag_set;
    mc_set[0] |=> o_modem_change_flag[0];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("modem change not recorded");
  property p_w1c;
    mc_clr[1] && !mc_set[1] |=> !o_modem_change_flag[1];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear the flag");
  property p_isr_read;
    acc_start && bus_wr_n && sel_isr |=> o_data[6:4] == 3'h0
    && o_data[ISR_REQ_BIT] == $past(state == STOP);
  endproperty
  a_isr_read: assert property (p_isr_read)
    else $error("interrupt summary read wrong");
endmodule : ous_int_scanner

// File: verification/ous_host_model.sv
// Host processor model that reaches the summary registers over the bus pins
`timescale 1ns/1ps
module ous_host_model (
  // Clock
  input wire logic i_clk,
  // Bus pins toward the device
  output logic o_cs_n,
  output logic o_ds_n,
  output logic o_wr_n,
  output logic [5:0] o_addr,
  output logic [7:0] o_data,
  // Read answer from the device
  input wire logic [7:0] i_data,
  input wire logic i_data_oe
);
  import ous_pkg::*;

  // Control pins idle high at time zero; address and data start at zero
  initial
  begin
    {o_cs_n, o_ds_n, o_wr_n} = CTL_IDLE;
    o_addr = 6'h00;
    o_data = 8'h00;
  end

  // One access: select and address a clock ahead of the strobe, hold for 12
  // clocks, then a gap of 6; the read answer is taken when the enable shows
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    q = 8'h00;
    ok = 1'b0;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    o_wr_n = ~wr;
    o_addr = a;
    o_data = d;
    @(negedge i_clk);
    o_ds_n = 1'b0;
    for (n = 0; n < 12; n++)
    begin
      @(negedge i_clk);
      // Take the byte at the first sample with the driver on
      if (!ok && i_data_oe === 1'b1)
      begin
        q = i_data;
        ok = 1'b1;
      end
    end
    o_ds_n = 1'b1;
    o_cs_n = 1'b1;
    // Released data lines no longer show the last byte
    o_data = ~o_data;
    repeat (6) @(negedge i_clk);
  endtask : access

  // Read the change summary, keep it and write it straight back
  task automatic read_clear(output logic [7:0] saved);
    logic [7:0] dummy;
    logic ok;
    access(1'b0, {3'h0, ADDR_MODEM_CHANGE}, 8'h00, saved, ok);
    access(1'b1, {3'h0, ADDR_MODEM_CHANGE}, saved, dummy, ok);
  endtask : read_clear
endmodule : ous_host_model

// File: verification/test_octal_uart_interrupt_scanner.sv
// Self-checking bench for the serial-line interrupt scanner
`timescale 1ns/1ps
module test_octal_uart_interrupt_scanner;
  import ous_pkg::*;
  // Clock, reset and line-side stimulus
  logic clk, rst_n, fpar, cs_n, ds_n, wr_n, oe, irq_n, dir, ok;
  logic [7:0] rdy, rie, mie, txe, tie, idle, rbr, thw, dsr, dcd;
  logic [1:0] fdb, fst;
  // Bus and status outputs
  logic [5:0] addr;
  logic [7:0] wdat, rdat, mcf, tfe, q, sv;
  logic [2:0] ln;
  logic [4:0] chb;
  // Bookkeeping
  int mismatches, num_checks, seed, i, k, j;

  ous_int_scanner i_dut (.i_clk(clk), .i_reset_n(rst_n), .i_cs_n(cs_n), .i_ds_n(ds_n),
    .i_wr_n(wr_n), .i_addr(addr), .i_data(wdat), .o_data(rdat), .o_data_oe(oe),
    .i_dsr(dsr), .i_dcd(dcd), .i_rx_data_ready(rdy), .i_rx_int_enable(rie),
    .i_modem_int_enable(mie), .i_tx_holding_empty(txe), .i_tx_int_enable(tie),
    .i_ser_idle(idle), .i_rx_buf_read(rbr), .i_tx_hold_write(thw),
    .i_fmt_data_bits(fdb), .i_fmt_parity(fpar), .i_fmt_stop(fst), .o_irq_n(irq_n),
    .o_int_line_number(ln), .o_int_direction(dir), .o_modem_change_flag(mcf),
    .o_tx_fully_empty(tfe), .o_char_half_bits(chb));

  ous_host_model i_host (.i_clk(clk), .o_cs_n(cs_n), .o_ds_n(ds_n), .o_wr_n(wr_n),
    .o_addr(addr), .o_data(wdat), .i_data(rdat), .i_data_oe(oe));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // The request is watched as a level, bounded to 40 clocks
  task automatic wait_irq();
    int n;
    for (n = 0; n < 40 && irq_n !== 1'b0; n++)
      @(negedge clk);
    if (irq_n !== 1'b0)
    begin
      mismatches++;
      $display("Error at %0t: no interrupt request", $time);
      tally_and_finish();
    end
  endtask : wait_irq

  // Character length in half bit times
  function automatic logic [4:0] exp_hb(input int d, input int p, input int s);
    exp_hb = 5'(2 * (6 + d + p) + ((s == 0) ? 2 : ((s == 1) ? 3 : 4)));
  endfunction : exp_hb

  // Hang guard
  initial
  begin
    #4000000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    seed = 63;
    mismatches = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {rdy, rie, mie, txe, tie, idle, rbr, thw, dsr, dcd} = '0;
    {fdb, fpar, fst} = 5'h00;
    repeat (4) @(negedge clk);
    dsr[3] = 1'b1; // change inside reset must not count
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk(mcf, 8'h00);
    // Free scan: one step per clock with wrap
    for (i = 0; i < 20; i++)
    begin
      q = {4'h0, dir, ln};
      @(negedge clk);
      chk({4'h0, dir, ln}, {4'h0, q[3:0] + 4'h1});
    end
    i_host.access(1'b0, {3'($random(seed)), 3'h5}, 8'h00, q, ok);
    chk({7'h0, ok}, 8'h00);
    i_host.access(1'b0, 6'h0e, 8'h00, q, ok);
    chk({q[7:4], 3'h0, ok}, 8'h01);
    // Modem change through the status pin, then write-one clear
    k = $unsigned($random(seed)) % 8;
    dsr[k] = ~dsr[k];
    repeat (8) @(negedge clk);
    chk(mcf, 8'h01 << k);
    i_host.access(1'b1, 6'h07, 8'h00, q, ok);
    chk(mcf, 8'h01 << k);
    rie[k] = 1'b1;
    mie[k] = 1'b1;
    wait_irq();
    chk({4'h0, dir, ln}, 8'(k));
    i_host.read_clear(sv);
    chk(sv, 8'h01 << k);
    chk({7'h0, irq_n}, 8'h01);
    chk(mcf, 8'h00);
    dcd[k] = ~dcd[k];
    wait_irq();
    mie[k] = 1'b0;
    @(negedge clk);
    chk({7'h0, irq_n}, 8'h01);
    i_host.access(1'b1, 6'h3f, 8'hff, q, ok);
    chk(mcf, 8'h00);
    rie[k] = 1'b0;
    // Receive stop, hold while stopped, resume; then transmit stop, restart
    for (i = 0; i < 4; i++)
    begin
      k = $unsigned($random(seed)) % 8;
      j = $unsigned($random(seed)) % 8;
      rdy[k] = 1'b1;
      rie[k] = 1'b1;
      wait_irq();
      chk({4'h0, dir, ln}, 8'(k));
      txe[j] = 1'b1;
      tie[j] = 1'b1;
      repeat (5) @(negedge clk);
      chk({3'h0, irq_n, dir, ln}, 8'(k));
      i_host.access(1'b0, {3'($random(seed)), 3'h6}, 8'h00, q, ok);
      chk(q, {1'b1, 3'h0, 3'(k), 1'b0});
      if (i[0])
      begin
        rbr[k] = 1'b1;
        rdy[k] = 1'b0;
      end
      else
        rie[k] = 1'b0;
      @(negedge clk);
      rbr[k] = 1'b0;
      chk({3'h0, irq_n, dir, ln}, 8'h10 + 8'(k + 1));
      wait_irq();
      chk({4'h0, dir, ln}, 8'h08 + 8'(j));
      if (i[1])
      begin
        thw[j] = 1'b1;
        txe[j] = 1'b0;
      end
      else
        tie[j] = 1'b0;
      @(negedge clk);
      thw[j] = 1'b0;
      chk({3'h0, irq_n, dir, ln}, 8'h10);
      {rdy, rie, txe, tie} = '0;
    end
    // Empty flags and character length over every format
    for (i = 0; i < 32; i++)
    begin
      txe = 8'($random(seed));
      idle = 8'($random(seed));
      {fdb, fpar, fst} = 5'(i);
      repeat (2) @(negedge clk);
      chk(tfe, txe & idle);
      chk({3'h0, chb}, {3'h0, exp_hb(fdb, fpar, fst)});
    end
    tally_and_finish();
  end
endmodule : test_octal_uart_interrupt_scanner
